// [src/mfzc_avg.sv]
`timescale 1ns/1ns
`default_nettype none
module mfzc_avg
    import mfzc_pkg::*;
(
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    // averaging path
    mfzc_avg_if.avg     bus
);

    logic [22:0] acc1_r;
    logic [22:0] acc2_r;
    logic [6:0]  cnt1_r;
    logic [6:0]  cnt2_r;
    logic        s1_vld_r;
    logic [15:0] st1_r;
    logic [15:0] st2_r;

    function automatic logic last_of(input logic [6:0] cnt,
                                     input logic [2:0] k);
        logic [7:0] n;
        n = 8'h01 << k;
        return ({1'b0, cnt} == n - 8'h01);
    endfunction

    function automatic logic [15:0] mean(input logic [22:0] acc,
                                         input logic [15:0] d,
                                         input logic [2:0]  k);
        logic [22:0] s;
        s = acc + {7'h00, d};
        return 16'(s >> k);
    endfunction

    // first stage on every routed result
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc1_r   <= 23'h000000;
            cnt1_r   <= 7'h00;
            st1_r    <= 16'h0000;
            s1_vld_r <= 1'b0;
        end else begin
            s1_vld_r <= 1'b0;
            if (bus.in_vld) begin
                if (last_of(cnt1_r, bus.k1)) begin
                    st1_r    <= mean(acc1_r, bus.in_dat, bus.k1);
                    acc1_r   <= 23'h000000;
                    cnt1_r   <= 7'h00;
                    s1_vld_r <= 1'b1;
                end else begin
                    acc1_r <= acc1_r + {7'h00, bus.in_dat};
                    cnt1_r <= cnt1_r + 7'h01;
                end
            end
        end
    end

    // second stage fed by the first stage output
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc2_r <= 23'h000000;
            cnt2_r <= 7'h00;
            st2_r  <= 16'h0000;
        end else if (s1_vld_r) begin
            if (last_of(cnt2_r, bus.k2)) begin
                st2_r  <= mean(acc2_r, st1_r, bus.k2);
                acc2_r <= 23'h000000;
                cnt2_r <= 7'h00;
            end else begin
                acc2_r <= acc2_r + {7'h00, st1_r};
                cnt2_r <= cnt2_r + 7'h01;
            end
        end
    end

    assign bus.st1 = st1_r;
    assign bus.st2 = st2_r;

endmodule
`default_nettype wire

// [src/mfzc_avg_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface mfzc_avg_if;
    logic        in_vld;
    logic [15:0] in_dat;
    logic [2:0]  k1;
    logic [2:0]  k2;
    logic [15:0] st1;
    logic [15:0] st2;
    modport src (output in_vld, in_dat, k1, k2, input st1, st2);
    modport avg (input in_vld, in_dat, k1, k2, output st1, st2);
endinterface
`default_nettype wire

// [src/mfzc_pkg.sv]
package mfzc_pkg;

    // clock and time figures
    localparam int CLK_PERIOD_NS     = 4;
    localparam int NS_PER_US         = 1000;
    localparam int ZC_PW_SHORT_US    = 32;
    localparam int ZC_PW_LONG_US     = 256;
    localparam int FLT_DLY_STEP_US   = 4;
    localparam int ZC_PW_SHORT_CYC   = ZC_PW_SHORT_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int ZC_PW_LONG_CYC    = ZC_PW_LONG_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int FLT_DLY_STEP_CYC  = FLT_DLY_STEP_US * NS_PER_US / CLK_PERIOD_NS;

    // field limits
    localparam logic [3:0]  FLT_DLY_MAX_STEPS = 4'h8;
    localparam logic [15:0] WIN_MIN_SAMPLES   = 16'h0004;
    localparam logic [2:0]  ZC_HOLDOFF_SMP    = 3'h7;
    localparam logic [11:0] FLT_THR_MIN       = 12'h533;
    localparam logic [11:0] FLT_THR_SPAN      = 12'hACC;
    localparam int          DEL_DEPTH         = 8;
    localparam int          DW                = 16;

    // register byte addresses
    localparam logic [7:0] ADDR_CFG0    = 8'h00;
    localparam logic [7:0] ADDR_CFG1    = 8'h04;
    localparam logic [7:0] ADDR_THR     = 8'h08;
    localparam logic [7:0] ADDR_FLT     = 8'h0C;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_AVG1_S1 = 8'h14;
    localparam logic [7:0] ADDR_AVG1_S2 = 8'h18;
    localparam logic [7:0] ADDR_AVG2_S1 = 8'h1C;
    localparam logic [7:0] ADDR_AVG2_S2 = 8'h20;

    // averaging source codes
    localparam logic [1:0] AVG_SRC_VRMS = 2'h0;
    localparam logic [1:0] AVG_SRC_IRMS = 2'h1;
    localparam logic [1:0] AVG_SRC_PACT = 2'h2;
    localparam logic [1:0] AVG_SRC_OFF  = 2'h3;

    // output-zero function codes
    localparam logic [1:0] DIO0_ZC    = 2'h0;
    localparam logic [1:0] DIO0_OV    = 2'h1;
    localparam logic [1:0] DIO0_UV    = 2'h2;
    localparam logic [1:0] DIO0_OV_UV = 2'h3;

    localparam logic       PROTO_TWO_WIRE = 1'b1;

    typedef struct packed {
        logic [7:0] rsvd;
        logic       zc_chan_curr;
        logic       square_en;
        logic       pw_long;
        logic       every_edge;
        logic       edge_rise;
        logic [1:0] dio0_sel;
        logic       proto_sel;
        logic       bypass_n;
        logic [2:0] avg_k2;
        logic [2:0] avg_k1;
        logic [1:0] avg2_sel;
        logic [1:0] avg1_sel;
        logic       del_sel_curr;
        logic [2:0] del_amt;
    } mfzc_cfg0_t;

    typedef struct packed {
        logic [7:0]  rsvd;
        logic [7:0]  vevent;
        logic [15:0] n_samples;
    } mfzc_cfg1_t;

    typedef struct packed {
        logic [15:0] uv_thr;
        logic [15:0] ov_thr;
    } mfzc_thr_t;

    typedef struct packed {
        logic [19:0] rsvd;
        logic [3:0]  flt_dly;
        logic [7:0]  fault_thr;
    } mfzc_flt_t;

    localparam logic [31:0] CFG0_RST = 32'h0000_1B50;
    localparam logic [31:0] CFG1_RST = 32'h0001_0200;
    localparam logic [31:0] THR_RST  = 32'h2000_C000;
    localparam logic [31:0] FLT_RST  = 32'h0000_0080;

endpackage

// [src/mfzc_top.sv]
// Summary of operation
// - selected channel delayed by programmed amount, at most about 5 degrees
// - delay-select bit picks voltage or current channel for the delay
// - two averaging paths; RMS voltage, RMS current or power routable
// - each path is two cascaded averaging stages; both paths share the two stage counts
// - every averaging stage result is readable for each path
// - RMS voltage compared with overvoltage and undervoltage thresholds
// - flag raised only after configured count of consecutive windows
// - overcurrent trip programmable between 0.65 and 2.0 rated range
// - programmable delay up to 32 us before fault is reported
// - window framed by voltage crossings unless bypass bit is set
// - bypass set: fixed window of programmed sample count
// - fixed counts below four are used as four
// - fixed mode: first valid result after twice the window count
// - two-wire protocol select turns two pins into digital outputs
// - digital outputs active low
// - output zero: 0 crossing, 1 over, 2 under, 3 over or under
// - framing only from voltage crossings; either channel reportable
// - edge select: 1 rising crossings, 0 falling crossings
// - every-edge bit pulses on both crossing polarities
// - pulse width 32 us when 0, 256 us when 1
// - square wave toggles per crossing, rising edge on selected edge
// - current crossings reported in pulse mode only
// - rising voltage crossing closes window and opens next one
// - overcurrent uses separate 12-bit 1 MHz current value
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module mfzc_top
    import mfzc_pkg::*;
#(
    parameter int ZC_PW_SHORT = ZC_PW_SHORT_CYC,
    parameter int ZC_PW_LONG  = ZC_PW_LONG_CYC,
    parameter int FLT_STEP    = FLT_DLY_STEP_CYC
) (
    // clock and reset
    input  wire logic          SYS_CLK_I,
    input  wire logic          RESET_N_I,
    // register port
    input  wire logic [7:0]    REG_ADDR_I,
    input  wire logic [31:0]   REG_WDATA_I,
    input  wire logic          REG_WR_I,
    input  wire logic          REG_RD_I,
    output logic      [31:0]   REG_RDATA_O,
    // 32 kHz sample stream
    input  wire logic          SAMPLE_TICK_I,
    input  wire logic [15:0]   VOLT_SAMPLE_I,
    input  wire logic [15:0]   CURR_SAMPLE_I,
    output logic               SAMPLE_VLD_O,
    output logic      [15:0]   VOLT_DEL_O,
    output logic      [15:0]   CURR_DEL_O,
    // window framing and results
    output logic               WINDOW_END_O,
    output logic               RMS_READY_O,
    input  wire logic          RMS_DONE_I,
    input  wire logic [15:0]   VRMS_I,
    input  wire logic [15:0]   IRMS_I,
    input  wire logic [15:0]   PACT_I,
    // 1 MHz overcurrent path
    input  wire logic          FAST_TICK_I,
    input  wire logic [11:0]   FAST_CURR_I,
    // flags and pins
    output logic               OV_FLAG_O,
    output logic               UV_FLAG_O,
    output logic               FAULT_O,
    output logic               DIO0_N_O,
    output logic               DIO1_N_O
);

    mfzc_cfg0_t  cfg0_r;
    mfzc_cfg1_t  cfg1_r;
    mfzc_thr_t   thr_r;
    mfzc_flt_t   flt_r;
    logic [31:0] rdata_r;

    logic [15:0] dl_r [DEL_DEPTH];
    logic [15:0] dl_in;
    logic [15:0] dl_out;
    logic [15:0] volt_del_r;
    logic [15:0] curr_del_r;
    logic        smp_vld_r;

    logic        v_sign_r;
    logic        c_sign_r;
    logic [2:0]  v_hold_r;
    logic [2:0]  c_hold_r;
    logic [1:0]  v_edge;
    logic [1:0]  c_edge;

    logic [15:0] win_cnt_r;
    logic [15:0] n_eff;
    logic        win_end_r;
    logic [1:0]  win_seen_r;
    logic        bypass_q_r;
    logic        ready_r;

    logic [7:0]  ov_cnt_r;
    logic [7:0]  uv_cnt_r;
    logic        ov_r;
    logic        uv_r;

    logic        over_r;
    logic [15:0] flt_cnt_r;
    logic [15:0] flt_target;
    logic        fault_r;

    logic        zc_report;
    logic [15:0] pw_cnt_r;
    logic        sq_r;
    logic        zc_level;
    logic        dio0_func;
    logic        dio0_n_r;
    logic        dio1_n_r;

    mfzc_avg_if avg1_if ();
    mfzc_avg_if avg2_if ();

    // crossing detector: {rise, fall} gated by time hysteresis
    function automatic logic [1:0] zc_detect(input logic       prev_neg,
                                             input logic       now_neg,
                                             input logic [2:0] hold);
        logic ok;
        ok = (hold == 3'h0);
        return {ok & prev_neg & ~now_neg, ok & ~prev_neg & now_neg};
    endfunction

    function automatic logic [7:0] evt_next(input logic       cond,
                                            input logic [7:0] cnt);
        if (!cond) begin
            return 8'h00;
        end
        return (cnt == 8'hFF) ? cnt : cnt + 8'h01;
    endfunction

    function automatic logic [15:0] route(input logic [1:0]  sel,
                                          input logic [15:0] v, c, p);
        if (sel == AVG_SRC_VRMS) begin
            return v;
        end else if (sel == AVG_SRC_IRMS) begin
            return c;
        end
        return p;
    endfunction

    // register writes
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cfg0_r <= mfzc_cfg0_t'(CFG0_RST);
            cfg1_r <= mfzc_cfg1_t'(CFG1_RST);
            thr_r  <= mfzc_thr_t'(THR_RST);
            flt_r  <= mfzc_flt_t'(FLT_RST);
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == ADDR_CFG0) begin
                cfg0_r <= mfzc_cfg0_t'(REG_WDATA_I);
            end else if (REG_ADDR_I == ADDR_CFG1) begin
                cfg1_r <= mfzc_cfg1_t'(REG_WDATA_I);
            end else if (REG_ADDR_I == ADDR_THR) begin
                thr_r <= mfzc_thr_t'(REG_WDATA_I);
            end else if (REG_ADDR_I == ADDR_FLT) begin
                flt_r <= mfzc_flt_t'(REG_WDATA_I);
            end
        end
    end

    // register reads, data valid the following cycle only
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rdata_r <= 32'h0000_0000;
        end else if (!REG_RD_I) begin
            rdata_r <= 32'h0000_0000;
        end else if (REG_ADDR_I == ADDR_CFG0) begin
            rdata_r <= {8'h00, cfg0_r[23:0]};
        end else if (REG_ADDR_I == ADDR_CFG1) begin
            rdata_r <= {8'h00, cfg1_r[23:0]};
        end else if (REG_ADDR_I == ADDR_THR) begin
            rdata_r <= thr_r;
        end else if (REG_ADDR_I == ADDR_FLT) begin
            rdata_r <= {20'h00000, flt_r[11:0]};
        end else if (REG_ADDR_I == ADDR_STATUS) begin
            rdata_r <= {28'h0000000, ready_r, fault_r, uv_r, ov_r};
        end else if (REG_ADDR_I == ADDR_AVG1_S1) begin
            rdata_r <= {16'h0000, avg1_if.st1};
        end else if (REG_ADDR_I == ADDR_AVG1_S2) begin
            rdata_r <= {16'h0000, avg1_if.st2};
        end else if (REG_ADDR_I == ADDR_AVG2_S1) begin
            rdata_r <= {16'h0000, avg2_if.st1};
        end else if (REG_ADDR_I == ADDR_AVG2_S2) begin
            rdata_r <= {16'h0000, avg2_if.st2};
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    // phase delay line, one sample per step
    assign dl_in  = cfg0_r.del_sel_curr ? CURR_SAMPLE_I : VOLT_SAMPLE_I;
    assign dl_out = (cfg0_r.del_amt == 3'h0) ? dl_in
                  : dl_r[cfg0_r.del_amt - 3'h1];

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            for (int i = 0; i < DEL_DEPTH; i++) begin
                dl_r[i] <= 16'h0000;
            end
        end else if (SAMPLE_TICK_I) begin
            dl_r[0] <= dl_in;
            for (int i = 1; i < DEL_DEPTH; i++) begin
                dl_r[i] <= dl_r[i-1];
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            volt_del_r <= 16'h0000;
            curr_del_r <= 16'h0000;
            smp_vld_r  <= 1'b0;
        end else begin
            smp_vld_r <= SAMPLE_TICK_I;
            if (SAMPLE_TICK_I) begin
                volt_del_r <= cfg0_r.del_sel_curr ? VOLT_SAMPLE_I : dl_out;
                curr_del_r <= cfg0_r.del_sel_curr ? dl_out : CURR_SAMPLE_I;
            end
        end
    end

    // crossings with hold-off
    assign v_edge = zc_detect(v_sign_r, volt_del_r[DW-1], v_hold_r);
    assign c_edge = zc_detect(c_sign_r, curr_del_r[DW-1], c_hold_r);

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            v_sign_r <= 1'b0;
            c_sign_r <= 1'b0;
            v_hold_r <= 3'h0;
            c_hold_r <= 3'h0;
        end else if (smp_vld_r) begin
            v_sign_r <= volt_del_r[DW-1];
            c_sign_r <= curr_del_r[DW-1];
            v_hold_r <= (|v_edge) ? ZC_HOLDOFF_SMP
                      : (v_hold_r == 3'h0) ? 3'h0 : v_hold_r - 3'h1;
            c_hold_r <= (|c_edge) ? ZC_HOLDOFF_SMP
                      : (c_hold_r == 3'h0) ? 3'h0 : c_hold_r - 3'h1;
        end
    end

    // window framing
    assign n_eff = (cfg1_r.n_samples < WIN_MIN_SAMPLES) ? WIN_MIN_SAMPLES
                 : cfg1_r.n_samples;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            win_cnt_r <= 16'h0000;
            win_end_r <= 1'b0;
        end else begin
            win_end_r <= 1'b0;
            if (smp_vld_r) begin
                if (cfg0_r.bypass_n) begin
                    if (win_cnt_r + 16'h0001 >= n_eff) begin
                        win_cnt_r <= 16'h0000;
                        win_end_r <= 1'b1;
                    end else begin
                        win_cnt_r <= win_cnt_r + 16'h0001;
                    end
                end else if (v_edge[1]) begin
                    win_cnt_r <= 16'h0000;
                    win_end_r <= 1'b1;
                end else if (win_cnt_r != 16'hFFFF) begin
                    win_cnt_r <= win_cnt_r + 16'h0001;
                end
            end
        end
    end

    // result readiness; restarted on a framing mode change
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            win_seen_r <= 2'h0;
            bypass_q_r <= 1'b0;
            ready_r    <= 1'b0;
        end else begin
            bypass_q_r <= cfg0_r.bypass_n;
            if (bypass_q_r != cfg0_r.bypass_n) begin
                win_seen_r <= 2'h0;
                ready_r    <= 1'b0;
            end else if (win_end_r && !ready_r) begin
                win_seen_r <= win_seen_r + 2'h1;
                ready_r    <= !cfg0_r.bypass_n
                           || (win_seen_r == 2'h1);
            end
        end
    end

    // voltage limit flags, one evaluation per finished window
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ov_cnt_r <= 8'h00;
            uv_cnt_r <= 8'h00;
            ov_r     <= 1'b0;
            uv_r     <= 1'b0;
        end else if (RMS_DONE_I) begin
            ov_cnt_r <= evt_next(VRMS_I > thr_r.ov_thr, ov_cnt_r);
            uv_cnt_r <= evt_next(VRMS_I < thr_r.uv_thr, uv_cnt_r);
            ov_r <= (VRMS_I > thr_r.ov_thr)
                 && (evt_next(1'b1, ov_cnt_r) >= cfg1_r.vevent);
            uv_r <= (VRMS_I < thr_r.uv_thr)
                 && (evt_next(1'b1, uv_cnt_r) >= cfg1_r.vevent);
        end
    end

    // overcurrent compare and delay
    assign flt_target = 16'((flt_r.flt_dly > FLT_DLY_MAX_STEPS
                        ? FLT_DLY_MAX_STEPS : flt_r.flt_dly) * FLT_STEP);

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            over_r <= 1'b0;
        end else if (FAST_TICK_I) begin
            over_r <= FAST_CURR_I >= FLT_THR_MIN
                    + 12'(({12'h000, flt_r.fault_thr} * {12'h000, FLT_THR_SPAN})
                    >> 8);
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            flt_cnt_r <= 16'h0000;
            fault_r   <= 1'b0;
        end else if (!over_r) begin
            flt_cnt_r <= 16'h0000;
            fault_r   <= 1'b0;
        end else begin
            if (flt_cnt_r < flt_target) begin
                flt_cnt_r <= flt_cnt_r + 16'h0001;
            end
            fault_r <= (flt_cnt_r >= flt_target);
        end
    end

    // crossing report selection
    always_comb begin
        logic [1:0] e;
        e = cfg0_r.zc_chan_curr ? c_edge : v_edge;
        if (!smp_vld_r) begin
            zc_report = 1'b0;
        end else if (cfg0_r.every_edge) begin
            zc_report = |e;
        end else begin
            zc_report = cfg0_r.edge_rise ? e[1] : e[0];
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pw_cnt_r <= 16'h0000;
        end else if (zc_report) begin
            pw_cnt_r <= cfg0_r.pw_long ? 16'(ZC_PW_LONG)
                      : 16'(ZC_PW_SHORT);
        end else if (pw_cnt_r != 16'h0000) begin
            pw_cnt_r <= pw_cnt_r - 16'h0001;
        end
    end

    // square wave follows voltage crossings only
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sq_r <= 1'b0;
        end else if (smp_vld_r && (|v_edge)) begin
            sq_r <= cfg0_r.edge_rise ? v_edge[1] : v_edge[0];
        end
    end

    assign zc_level = (cfg0_r.square_en && !cfg0_r.zc_chan_curr) ? sq_r
                    : (pw_cnt_r != 16'h0000);

    always_comb begin
        if (cfg0_r.dio0_sel == DIO0_ZC) begin
            dio0_func = zc_level;
        end else if (cfg0_r.dio0_sel == DIO0_OV) begin
            dio0_func = ov_r;
        end else if (cfg0_r.dio0_sel == DIO0_UV) begin
            dio0_func = uv_r;
        end else begin
            dio0_func = ov_r | uv_r;
        end
    end

    // pins idle high outside two-wire mode
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            dio0_n_r <= 1'b1;
            dio1_n_r <= 1'b1;
        end else begin
            dio0_n_r <= !((cfg0_r.proto_sel == PROTO_TWO_WIRE)
                      && dio0_func);
            dio1_n_r <= !((cfg0_r.proto_sel == PROTO_TWO_WIRE)
                      && fault_r);
        end
    end

    // averaging paths
    assign avg1_if.in_vld = RMS_DONE_I && (cfg0_r.avg1_sel != AVG_SRC_OFF);
    assign avg1_if.in_dat = route(cfg0_r.avg1_sel, VRMS_I, IRMS_I, PACT_I);
    assign avg1_if.k1     = cfg0_r.avg_k1;
    assign avg1_if.k2     = cfg0_r.avg_k2;
    assign avg2_if.in_vld = RMS_DONE_I && (cfg0_r.avg2_sel != AVG_SRC_OFF);
    assign avg2_if.in_dat = route(cfg0_r.avg2_sel, VRMS_I, IRMS_I, PACT_I);
    assign avg2_if.k1     = cfg0_r.avg_k1;
    assign avg2_if.k2     = cfg0_r.avg_k2;

    mfzc_avg u_avg1 (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RESET_N_I),
        .bus     (avg1_if.avg)
    );

    mfzc_avg u_avg2 (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RESET_N_I),
        .bus     (avg2_if.avg)
    );

    assign REG_RDATA_O  = rdata_r;
    assign SAMPLE_VLD_O = smp_vld_r;
    assign VOLT_DEL_O   = volt_del_r;
    assign CURR_DEL_O   = curr_del_r;
    assign WINDOW_END_O = win_end_r;
    assign RMS_READY_O  = ready_r;
    assign OV_FLAG_O    = ov_r;
    assign UV_FLAG_O    = uv_r;
    assign FAULT_O      = fault_r;
    assign DIO0_N_O     = dio0_n_r;
    assign DIO1_N_O     = dio1_n_r;

endmodule
`default_nettype wire

// [verif/mfzc_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module mfzc_checker
    import mfzc_pkg::*;
(
    // watched top-level ports
    input wire logic        SYS_CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic        SAMPLE_TICK_I,
    input wire logic        SAMPLE_VLD_O,
    input wire logic [15:0] VOLT_DEL_O,
    input wire logic        WINDOW_END_O,
    input wire logic        RMS_READY_O,
    input wire logic        RMS_DONE_I,
    input wire logic        FAST_TICK_I,
    input wire logic [11:0] FAST_CURR_I,
    input wire logic        OV_FLAG_O,
    input wire logic        UV_FLAG_O,
    input wire logic        FAULT_O,
    input wire logic        DIO1_N_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    AST_VLD: assert property (SAMPLE_TICK_I |=> SAMPLE_VLD_O)
        else $error("sample valid missing");
    AST_DEL: assert property (!$past(SAMPLE_TICK_I) |->
        $stable(VOLT_DEL_O)) else $error("delayed sample moved");
    AST_WIN: assert property (WINDOW_END_O |->
        $past(SAMPLE_TICK_I, 2)) else $error("window end without tick");
    AST_RDY: assert property ($rose(RMS_READY_O) |->
        WINDOW_END_O || $past(WINDOW_END_O)) else $error("early ready");
    AST_OVH: assert property ($changed(OV_FLAG_O) |->
        $past(RMS_DONE_I)) else $error("over flag moved");
    AST_UVH: assert property ($changed(UV_FLAG_O) |->
        $past(RMS_DONE_I)) else $error("under flag moved");
    AST_FLT: assert property (FAST_TICK_I && FAST_CURR_I < FLT_THR_MIN
        |-> ##2 !FAULT_O) else $error("fault not cleared");
    AST_DIO1: assert property (!DIO1_N_O |-> $past(FAULT_O))
        else $error("pin without fault");
    AST_RD: assert property (!$past(REG_RD_I) |->
        REG_RDATA_O == 32'h0) else $error("read data outside slot");
endmodule
bind mfzc_top mfzc_checker i_chk (.SYS_CLK_I(SYS_CLK_I),
    .RESET_N_I(RESET_N_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .SAMPLE_TICK_I(SAMPLE_TICK_I), .SAMPLE_VLD_O(SAMPLE_VLD_O),
    .VOLT_DEL_O(VOLT_DEL_O), .WINDOW_END_O(WINDOW_END_O),
    .RMS_READY_O(RMS_READY_O), .RMS_DONE_I(RMS_DONE_I),
    .FAST_TICK_I(FAST_TICK_I), .FAST_CURR_I(FAST_CURR_I),
    .OV_FLAG_O(OV_FLAG_O), .UV_FLAG_O(UV_FLAG_O), .FAULT_O(FAULT_O),
    .DIO1_N_O(DIO1_N_O));
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
    import mfzc_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        tk = 1'b0, dn = 1'b0, ft = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [15:0] vs = 16'h0, cs = 16'h0, vr = 16'h0, pa = 16'h0, vd, cd;
    logic [11:0] fc = 12'h000;
    logic        ov, uv, flt, dio0, dio1;
    logic [15:0] h [0:9];
    logic [15:0] tv [0:4];
    logic        ex [0:4], eu [0:4];
    integer      mismatches = 0, comparisons = 0, seed = 30598, i;
    mfzc_top #(.ZC_PW_SHORT(8), .ZC_PW_LONG(64), .FLT_STEP(4)) i_dut (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(adr),
        .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
        .SAMPLE_TICK_I(tk), .VOLT_SAMPLE_I(vs), .CURR_SAMPLE_I(cs),
        .SAMPLE_VLD_O(), .VOLT_DEL_O(vd), .CURR_DEL_O(cd),
        .WINDOW_END_O(), .RMS_READY_O(), .RMS_DONE_I(dn), .VRMS_I(vr),
        .IRMS_I(~vr), .PACT_I(pa), .FAST_TICK_I(ft), .FAST_CURR_I(fc),
        .OV_FLAG_O(ov), .UV_FLAG_O(uv), .FAULT_O(flt), .DIO0_N_O(dio0),
        .DIO1_N_O(dio1));
    always #2 clk = ~clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task give_verdict;
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rdk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict;
    end
    initial begin
        tv = '{16'h9000, 16'h9000, 16'h0800, 16'h0800, 16'h9000};
        ex = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        eu = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdk(ADDR_CFG0, CFG0_RST);
        rdk(ADDR_CFG1, CFG1_RST);
        rdk(ADDR_THR, THR_RST);
        rdk(ADDR_FLT, FLT_RST);
        rdk(8'hFC, 32'h0);
        // two-wire pins, out0 = over flag, delay 2 on voltage, path2 = power
        wrr(ADDR_CFG0, 32'h0001_8082);
        wrr(ADDR_CFG1, 32'h0002_0010);
        wrr(ADDR_THR, 32'h1000_8000);
        wrr(ADDR_FLT, 32'h0);
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            h[i] = 16'($random(seed));
            vs <= h[i];
            cs <= ~h[i];
            tk <= 1'b1;
            @(posedge clk);
            tk <= 1'b0;
            #1;
            if (i > 1) chk(vd, h[i-2]);
            chk(cd, 16'(~h[i]));
            @(posedge clk);
        end
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            vr <= tv[i];
            pa <= 16'($random(seed));
            dn <= 1'b1;
            @(posedge clk);
            dn <= 1'b0;
            @(posedge clk);
            #1 chk(ov, ex[i]);
            chk(uv, eu[i]);
            repeat (2) @(posedge clk);
            #1 chk(dio0, !ex[i]);
        end
        rdk(ADDR_AVG1_S1, 32'h9000);
        rdk(ADDR_AVG1_S2, 32'h9000);
        rdk(ADDR_AVG2_S1, {16'h0, pa});
        // threshold boundary: equal trips, one below clears
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            fc <= 12'h533 - 12'(i);
            ft <= 1'b1;
            @(posedge clk);
            ft <= 1'b0;
            repeat (2) @(posedge clk);
            #1 chk(flt, i == 0);
            @(posedge clk);
            #1 chk(dio1, i != 0);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
